/* File: design/mtseq_pkg.sv */
// Shared constants and types for the measurement trigger sequencer
package mtseq_pkg;
    localparam int MTSEQ_CLK_HZ = 50_000_000;
    localparam int MTSEQ_SETUP_MS = 20;
    localparam int MTSEQ_SETUP_CYC = MTSEQ_SETUP_MS * (MTSEQ_CLK_HZ / 1000);
    localparam int MTSEQ_MS_CYC = MTSEQ_CLK_HZ / 1000;
    localparam int MTSEQ_MEM_DEPTH = 1024;
    localparam int MTSEQ_MAX_COUNT = 50000;
    localparam int MTSEQ_MAX_DELAY_MS = 3600000;
    localparam int MTSEQ_FIFO_DEPTH = 8;
    localparam logic [15:0] MTSEQ_COUNT_ONE = 16'h0001;
    localparam logic [21:0] MTSEQ_DELAY_ZERO = 22'h000000;
    // Stand-in for the infinite trigger count code, float text lives above us
    localparam logic [15:0] MTSEQ_COUNT_INF_CODE = 16'hffff;

    typedef enum logic [1:0] {MTSEQ_SRC_IMM, MTSEQ_SRC_BUS, MTSEQ_SRC_EXT} mtseq_src_t;
    typedef enum logic [1:0] {MTSEQ_MATH_OFF, MTSEQ_MATH_STATS, MTSEQ_MATH_SCALE} mtseq_math_t;

    typedef struct packed {
        logic signed [31:0] min_val;
        logic signed [31:0] max_val;
        logic signed [31:0] mean_val;
        logic [31:0] count;
        logic [31:0] peak_to_peak_result;
    } mtseq_stats_t;

    typedef struct packed {
        logic signed [15:0] gain;
        logic signed [31:0] offset;
    } mtseq_scale_t;
endpackage

/* File: design/mtseq_fifo.sv */
// Parameterised valid/ready FIFO for readings
`timescale 1ns/1ps
`default_nettype none
module mtseq_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("mtseq_fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;
    wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    wire empty = (wr_r == rd_r);
    wire push = in_valid && !full;
    wire pop = !empty && out_ready;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_r[rd_r[AW-1:0]];
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wr_r <= '0;
            rd_r <= '0;
        end
        else
        begin
            if (push)
                wr_r <= wr_r + 1'b1;
            if (pop)
                rd_r <= rd_r + 1'b1;
        end
    end
    always_ff @(posedge clock)
    begin
        if (push)
            mem_r[wr_r[AW-1:0]] <= in_data;
    end
endmodule
`default_nettype wire

/* File: design/mtseq_top.sv */
// Trigger sequencer with reading memory, statistics and scaling
//
// Behaviour
// - Only one math function, statistics or scaling, active at once.
// - Statistics keep smallest reading seen.
// - Statistics keep largest reading seen.
// - Mean of all readings since statistics enabled is returned.
// - Count of readings since statistics enabled is returned.
// - Peak-to-peak equals largest minus smallest reading.
// - Statistics clear on math enable, power loss and remote reset.
// - Storage enabled by default keeps up to 1024 readings.
// - Storage off: no store, unlimited statistics, fetch raises error.
// - Scaling gives gain times reading plus offset.
// - Triggers outside wait-for-trigger are ignored; accepted one starts sequence.
// - External triggers discarded for 20 ms after arming.
// - One trigger source selected: bus, external or immediate (default).
// - Arm-and-store goes idle to waiting, readings into memory.
// - Arm-and-read goes idle to waiting, readings to output buffer.
// - Delay of 0 to 3600 s before every sample after trigger.
// - Automatic delay supported; explicit delay write disables it.
// - Samples per trigger 1 to 50000.
// - Trigger count 1 to 50000 then idle; infinite until device clear.
// - Infinite trigger count reports the infinity code.
// - Local operation ignores trigger count, accepts when not measuring.
`timescale 1ns/1ps
`default_nettype none
module mtseq_top
import mtseq_pkg::*;
#(
    parameter int SETUP_CYC = MTSEQ_SETUP_CYC,
    parameter int MS_CYC = MTSEQ_MS_CYC,
    parameter int FIFO_DEPTH = MTSEQ_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic remote_reset,
    input wire logic device_clear,
    input wire mtseq_src_t trig_source,
    input wire logic arm_store,
    input wire logic arm_read,
    input wire logic bus_trigger,
    input wire logic ext_trigger,
    input wire logic local_mode,
    input wire logic [15:0] sample_count,
    input wire logic [15:0] trigger_count,
    input wire logic trigger_infinite,
    input wire logic delay_write,
    input wire logic [21:0] delay_ms,
    input wire logic auto_delay_on,
    input wire logic [21:0] auto_delay_ms,
    input wire logic reading_memory_feed,
    input wire mtseq_math_t math_select,
    input wire logic math_on,
    input wire mtseq_scale_t scale_cfg,
    input wire logic sample_valid,
    input wire logic signed [31:0] sample_data,
    input wire logic fetch_req,
    input wire logic [9:0] mem_rd_index,
    output logic sample_start,
    output logic [31:0] mem_rd_data,
    output logic [10:0] mem_points,
    output logic out_valid,
    input wire logic out_ready,
    output logic [31:0] out_data,
    output mtseq_stats_t stats,
    output logic [15:0] trig_count_report,
    output logic stats_active,
    output logic scale_active,
    output logic auto_delay,
    output logic busy,
    output logic done,
    output logic fetch_error
);
    initial
    begin
        if (SETUP_CYC < 1 || MS_CYC < 1 || FIFO_DEPTH < 2)
            $error("mtseq_top parameter out of range");
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    typedef enum {ST_IDLE, ST_WAIT, ST_DELAY, ST_SAMPLE} mtseq_state_t;
    mtseq_state_t state_r;
    logic [31:0] setup_cnt_r;
    logic [31:0] ms_cnt_r;
    logic [21:0] delay_cnt_r;
    logic [15:0] samp_left_r;
    logic [15:0] trig_left_r;
    logic to_memory_r;
    logic auto_delay_r;
    logic auto_on_d_r;
    logic sample_pending_r;
    logic fifo_in_ready;

    wire clear_all = device_clear || remote_reset;
    wire arm = arm_store || arm_read;
    wire setup_over = (setup_cnt_r == '0);
    wire ext_ok = ext_trigger && setup_over;
    wire trig_hit = (trig_source == MTSEQ_SRC_IMM) ||
                    (trig_source == MTSEQ_SRC_BUS && bus_trigger) ||
                    (trig_source == MTSEQ_SRC_EXT && ext_ok);
    wire [21:0] delay_use = auto_delay_r ? auto_delay_ms : delay_ms;
    wire ms_tick = (ms_cnt_r == '0);
    wire last_sample = (samp_left_r == MTSEQ_COUNT_ONE);
    wire last_trig = !local_mode && !trigger_infinite && (trig_left_r == MTSEQ_COUNT_ONE);
    // Reading is taken when storing to memory (even if full or feed off) or when the FIFO has room
    wire can_sample = to_memory_r || fifo_in_ready;
    wire samp_done = (state_r == ST_SAMPLE) && sample_pending_r && sample_valid;

    always_ff @(posedge clock)
    begin
        auto_on_d_r <= auto_delay_on;
        if (!rst_n || remote_reset)
            auto_delay_r <= 1'b1;
        else if (delay_write)
            auto_delay_r <= 1'b0;
        else if (auto_delay_on != auto_on_d_r)
            auto_delay_r <= auto_delay_on;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n || clear_all)
        begin
            state_r <= ST_IDLE;
            setup_cnt_r <= '0;
            ms_cnt_r <= '0;
            delay_cnt_r <= '0;
            samp_left_r <= MTSEQ_COUNT_ONE;
            trig_left_r <= MTSEQ_COUNT_ONE;
            to_memory_r <= 1'b1;
            sample_pending_r <= 1'b0;
            sample_start <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            sample_start <= 1'b0;
            done <= 1'b0;
            if (setup_cnt_r != '0)
                setup_cnt_r <= setup_cnt_r - 1'b1;
            unique case (state_r)
                ST_IDLE:
                begin
                    if (arm || local_mode)
                    begin
                        state_r <= ST_WAIT;
                        to_memory_r <= arm_store || (local_mode && !arm_read);
                        setup_cnt_r <= 32'(SETUP_CYC);
                        trig_left_r <= (trigger_count == '0) ? MTSEQ_COUNT_ONE : trigger_count;
                    end
                end
                ST_WAIT:
                begin
                    if (trig_hit)
                    begin
                        state_r <= ST_DELAY;
                        samp_left_r <= (sample_count == '0) ? MTSEQ_COUNT_ONE : sample_count;
                        delay_cnt_r <= delay_use;
                        ms_cnt_r <= 32'(MS_CYC - 1);
                    end
                end
                ST_DELAY:
                begin
                    if (delay_cnt_r == MTSEQ_DELAY_ZERO)
                    begin
                        if (can_sample)
                        begin
                            state_r <= ST_SAMPLE;
                            sample_start <= 1'b1;
                            sample_pending_r <= 1'b1;
                        end
                    end
                    else if (ms_tick)
                    begin
                        delay_cnt_r <= delay_cnt_r - 1'b1;
                        ms_cnt_r <= 32'(MS_CYC - 1);
                    end
                    else
                        ms_cnt_r <= ms_cnt_r - 1'b1;
                end
                ST_SAMPLE:
                begin
                    if (samp_done)
                    begin
                        sample_pending_r <= 1'b0;
                        if (!last_sample)
                        begin
                            samp_left_r <= samp_left_r - 1'b1;
                            state_r <= ST_DELAY;
                            delay_cnt_r <= delay_use;
                            ms_cnt_r <= 32'(MS_CYC - 1);
                        end
                        else if (last_trig || local_mode)
                        begin
                            state_r <= ST_IDLE;
                            done <= 1'b1;
                        end
                        else
                        begin
                            trig_left_r <= trig_left_r - 1'b1;
                            state_r <= ST_WAIT;
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Math: scaling and statistics
    // ----------------------------------------------------------------
    // single math function
    wire stats_on = math_on && (math_select == MTSEQ_MATH_STATS);
    wire scale_on = math_on && (math_select == MTSEQ_MATH_SCALE);
    logic math_on_d_r;
    wire signed [47:0] prod = sample_data * scale_cfg.gain;
    wire signed [31:0] scaled = 32'(prod) + scale_cfg.offset;
    wire signed [31:0] reading = scale_on ? scaled : sample_data;
    logic signed [63:0] sum_r;
    logic signed [31:0] min_r;
    logic signed [31:0] max_r;
    logic [31:0] cnt_r;
    logic [31:0] mean_r;
    wire stats_clear = clear_all || (math_on && !math_on_d_r);

    always_ff @(posedge clock)
    begin
        if (!rst_n || stats_clear)
        begin
            sum_r <= '0;
            min_r <= '0;
            max_r <= '0;
            cnt_r <= '0;
        end
        else if (samp_done && stats_on)
        begin
            min_r <= (cnt_r == '0 || reading < min_r) ? reading : min_r;
            max_r <= (cnt_r == '0 || reading > max_r) ? reading : max_r;
            cnt_r <= cnt_r + 1'b1;
            sum_r <= sum_r + 64'(reading);
        end
    end

    // Mean by repeated divide is too slow; a one-shot divide keeps it simple
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            math_on_d_r <= 1'b0;
            mean_r <= '0;
            stats <= '0;
            stats_active <= 1'b0;
            scale_active <= 1'b0;
            auto_delay <= 1'b1;
            trig_count_report <= MTSEQ_COUNT_ONE;
            busy <= 1'b0;
        end
        else
        begin
            math_on_d_r <= math_on;
            mean_r <= (cnt_r == '0) ? '0 : 32'(sum_r / $signed({1'b0, cnt_r}));
            stats.min_val <= min_r;
            stats.max_val <= max_r;
            stats.mean_val <= mean_r;
            stats.count <= cnt_r;
            stats.peak_to_peak_result <= max_r - min_r;
            stats_active <= stats_on;
            scale_active <= scale_on;
            auto_delay <= auto_delay_r;
            trig_count_report <= trigger_infinite ? MTSEQ_COUNT_INF_CODE : trigger_count;
            busy <= (state_r != ST_IDLE);
        end
    end

    // ----------------------------------------------------------------
    // Reading memory and output path
    // ----------------------------------------------------------------
    logic [31:0] mem_r [MTSEQ_MEM_DEPTH];
    logic [10:0] points_r;
    wire mem_full = (points_r == 11'(MTSEQ_MEM_DEPTH));
    wire mem_wr = samp_done && to_memory_r && reading_memory_feed && !mem_full;

    always_ff @(posedge clock)
    begin
        if (mem_wr)
            mem_r[points_r[9:0]] <= reading;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n || clear_all || (state_r == ST_IDLE && arm_store))
            points_r <= '0;
        else if (mem_wr)
            points_r <= points_r + 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            mem_rd_data <= '0;
            mem_points <= '0;
            fetch_error <= 1'b0;
        end
        else
        begin
            mem_rd_data <= mem_r[mem_rd_index];
            mem_points <= points_r;
            fetch_error <= fetch_req && !reading_memory_feed;
        end
    end

    wire fifo_push = samp_done && !to_memory_r;
    logic fifo_out_valid;
    logic [31:0] fifo_out_data;

    mtseq_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(reading),
        .out_valid(fifo_out_valid),
        .out_ready(!out_valid || out_ready),
        .out_data(fifo_out_data)
    );

    // Output register stage so the port comes from a flop
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else if (!out_valid || out_ready)
        begin
            out_valid <= fifo_out_valid;
            out_data <= fifo_out_data;
        end
    end
endmodule
`default_nettype wire

/* File: verif/mtseq_checker.sv */
// Port-level assertions for the measurement trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module mtseq_checker
import mtseq_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic arm_store,
    input wire logic remote_reset,
    input wire logic device_clear,
    input wire logic local_mode,
    input wire logic fetch_req,
    input wire logic reading_memory_feed,
    input wire logic trigger_infinite,
    input wire logic math_on,
    input wire mtseq_math_t math_select,
    input wire logic sample_valid,
    input wire logic signed [31:0] sample_data,
    input wire logic sample_start,
    input wire mtseq_stats_t stats,
    input wire logic [15:0] trig_count_report,
    input wire logic stats_active,
    input wire logic scale_active,
    input wire logic busy,
    input wire logic done,
    input wire logic fetch_error
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_done_idle;
        done |=> !done && !busy;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("done not a pulse into idle");

    property p_arm_taken;
        arm_store && !busy && !remote_reset && !device_clear && !local_mode |-> ##2 busy;
    endproperty
    a_arm_taken: assert property (p_arm_taken) else $error("arm from idle not taken");

    property p_one_math;
        !(stats_active && scale_active);
    endproperty
    a_one_math: assert property (p_one_math) else $error("two math functions active");

    property p_stats_clear;
        $rose(math_on) && math_select == MTSEQ_MATH_STATS && !sample_valid |-> ##2 stats.count == 32'h0;
    endproperty
    a_stats_clear: assert property (p_stats_clear) else $error("count not cleared on math on");

    property p_count_step;
        stats_active && sample_valid && !$rose(math_on) && !remote_reset && !device_clear |->
            ##2 stats.count == $past(stats.count) + 32'h1;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not step");

    property p_min_max;
        stats_active && sample_valid && stats.count != 32'h0 && !remote_reset && !device_clear |->
            ##2 stats.min_val <= $past(sample_data, 2) && stats.max_val >= $past(sample_data, 2);
    endproperty
    a_min_max: assert property (p_min_max) else $error("min or max misses a reading");

    property p_ptp;
        stats_active && $stable(stats.min_val) && $stable(stats.max_val) |->
            stats.peak_to_peak_result == stats.max_val - stats.min_val;
    endproperty
    a_ptp: assert property (p_ptp) else $error("peak to peak not max minus min");

    property p_fetch_err;
        fetch_req && !reading_memory_feed |=> fetch_error;
    endproperty
    a_fetch_err: assert property (p_fetch_err) else $error("fetch without storage not flagged");

    property p_inf_code;
        trigger_infinite [*2] |-> trig_count_report == MTSEQ_COUNT_INF_CODE;
    endproperty
    a_inf_code: assert property (p_inf_code) else $error("infinite count code wrong");

    property p_start_busy;
        sample_start |-> busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("sample started while idle");
endmodule
`default_nettype wire

/* File: verif/mtseq_conv_model.sv */
// Converter stand-in answering each sample start with one reading
`timescale 1ns/1ps
`default_nettype none
module mtseq_conv_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sample_start,
    input wire logic slow,
    input wire logic signed [31:0] next_value,
    output logic sample_valid,
    output logic signed [31:0] sample_data
);
    int wait_r;
    always_ff @(posedge clock)
    begin
        sample_valid <= 1'b0;
        // Bus toggles between results so a stale reading never looks valid
        sample_data <= ~sample_data;
        if (!rst_n)
        begin
            wait_r <= 0;
            sample_data <= 32'h5a5a5a5a;
        end
        else if (sample_start && !slow)
        begin
            sample_valid <= 1'b1;
            sample_data <= next_value;
        end
        else if (sample_start)
            wait_r <= 3;
        else if (wait_r == 1)
        begin
            sample_valid <= 1'b1;
            sample_data <= next_value;
            wait_r <= 0;
        end
        else if (wait_r > 1)
            wait_r <= wait_r - 1;
    end
endmodule
`default_nettype wire

/* File: verif/measurement_trigger_sequencer_tb.sv */
// Self-checking bench for the measurement trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module measurement_trigger_sequencer_tb;
import mtseq_pkg::*;
    localparam int SETUP = 10;
    logic clock = 1'b0, rst_n = 1'b0, remote_reset = 1'b0, local_mode = 1'b0;
    logic device_clear = 1'b0, arm_store = 1'b0, arm_read = 1'b0, bus_trigger = 1'b0;
    logic ext_trigger = 1'b0, trigger_infinite = 1'b0, delay_write = 1'b0, slow = 1'b0;
    logic auto_delay_on = 1'b0, reading_memory_feed = 1'b1, math_on = 1'b0, fetch_req = 1'b0;
    logic out_ready = 1'b1, sample_valid, sample_start, out_valid, stats_active, scale_active;
    logic auto_delay, busy, done, fetch_error;
    logic [15:0] sample_count = 16'h0001, trigger_count = 16'h0001, trig_count_report;
    logic [15:0] seed = 16'h000d;
    logic [21:0] delay_ms = 22'h000000, auto_delay_ms = 22'h000000;
    logic [9:0] mem_rd_index = 10'h000;
    logic [10:0] mem_points;
    logic [31:0] mem_rd_data, out_data;
    logic signed [31:0] sample_data, next_value = 32'h0;
    mtseq_src_t trig_source = MTSEQ_SRC_IMM;
    mtseq_math_t math_select = MTSEQ_MATH_OFF;
    mtseq_scale_t scale_cfg = '0;
    mtseq_stats_t stats;
    logic signed [31:0] q_in[$];
    logic [31:0] q_out[$];
    int err_total = 0, compares = 0, n_start = 0, n0, mn, mx, sum;

    mtseq_top #(.SETUP_CYC(SETUP), .MS_CYC(2), .FIFO_DEPTH(8)) u_dut (.clock, .rst_n,
        .remote_reset, .device_clear, .trig_source, .arm_store, .arm_read, .bus_trigger,
        .ext_trigger, .local_mode, .sample_count, .trigger_count, .trigger_infinite,
        .delay_write, .delay_ms, .auto_delay_on, .auto_delay_ms, .reading_memory_feed,
        .math_select, .math_on, .scale_cfg, .sample_valid, .sample_data, .fetch_req,
        .mem_rd_index, .sample_start, .mem_rd_data, .mem_points, .out_valid, .out_ready,
        .out_data, .stats, .trig_count_report, .stats_active, .scale_active, .auto_delay,
        .busy, .done, .fetch_error);
    mtseq_conv_model u_conv (.clock, .rst_n, .sample_start, .slow, .next_value,
        .sample_valid, .sample_data);

    always #10 clock = ~clock;

    // ----------------------------------------
    // Stimulus source and result capture
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    always @(negedge clock)
    begin
        seed = lfsr(seed);
        next_value = {16'h0000, seed};
    end
    always @(posedge clock)
    begin
        if (sample_valid === 1'b1) q_in.push_back(sample_data);
        if (out_valid === 1'b1 && out_ready === 1'b1) q_out.push_back(out_data);
        if (sample_start === 1'b1) n_start++;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_done(input int bound);
        int n;
        n = 0;
        while (done !== 1'b1 && n < bound)
        begin
            @(negedge clock);
            n++;
        end
        if (done !== 1'b1)
        begin
            err_total++;
            $display("wrong value done expected 1 seen timeout");
            close_out();
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        chk("auto_delay", 1, auto_delay);
        chk("trig_count_report", 1, trig_count_report);
        repeat (2) @(negedge clock);
        chk("auto_delay", 1, auto_delay);
        delay_ms = 22'h000001;
        delay_write = 1'b1;
        @(negedge clock) delay_write = 1'b0;
        @(negedge clock) chk("auto_delay", 0, auto_delay);
        // Stats picked and math on before any result is trusted
        math_select = MTSEQ_MATH_STATS;
        math_on = 1'b1;
        sample_count = 16'h0003;
        trigger_count = 16'h0002;
        @(negedge clock) arm_store = 1'b1;
        @(negedge clock) arm_store = 1'b0;
        wait_done(400);
        repeat (3) @(negedge clock);
        mn = q_in[0];
        mx = q_in[0];
        sum = 0;
        foreach (q_in[i])
        begin
            sum += q_in[i];
            if (q_in[i] < mn) mn = q_in[i];
            if (q_in[i] > mx) mx = q_in[i];
        end
        chk("start count", 6, n_start);
        chk("count", q_in.size(), stats.count);
        chk("min", mn, stats.min_val);
        chk("max", mx, stats.max_val);
        chk("mean", sum / q_in.size(), stats.mean_val);
        chk("ptp", mx - mn, stats.peak_to_peak_result);
        chk("math flags", 2, {stats_active, scale_active});
        chk("mem_points", 6, mem_points);
        for (int i = 0; i < 6; i++)
        begin
            @(negedge clock) mem_rd_index = 10'(i);
            @(negedge clock) chk("mem_rd_data", q_in[i], mem_rd_data);
        end
        reading_memory_feed = 1'b0;
        fetch_req = 1'b1;
        @(negedge clock) fetch_req = 1'b0;
        chk("fetch_error", 1, fetch_error);
        math_on = 1'b0;
        @(negedge clock) math_select = MTSEQ_MATH_SCALE;
        math_on = 1'b1;
        scale_cfg = '{gain: 16'sh0003, offset: -32'sd5};
        trig_source = MTSEQ_SRC_BUS;
        sample_count = 16'h000c;
        trigger_count = 16'h0001;
        out_ready = 1'b0;
        slow = 1'b1;
        q_in.delete();
        n0 = n_start;
        bus_trigger = 1'b1;
        @(negedge clock) bus_trigger = 1'b0;
        repeat (3) @(negedge clock);
        chk("idle trigger", n0, n_start);
        chk("scale flags", 1, {stats_active, scale_active});
        arm_read = 1'b1;
        @(negedge clock) arm_read = 1'b0;
        repeat (3) @(negedge clock) bus_trigger = 1'b1;
        @(negedge clock) bus_trigger = 1'b0;
        repeat (100) @(negedge clock);
        chk("stalled", 1, busy && q_in.size() < 12 && out_valid);
        out_ready = 1'b1;
        wait_done(400);
        repeat (4) @(negedge clock);
        chk("out count", 12, q_out.size());
        foreach (q_out[i]) chk("scaled", q_in[i] * 3 - 5, q_out[i]);
        chk("drained", 0, out_valid);
        math_on = 1'b0;
        reading_memory_feed = 1'b1;
        trig_source = MTSEQ_SRC_EXT;
        sample_count = 16'h0001;
        ext_trigger = 1'b1;
        n0 = n_start;
        arm_store = 1'b1;
        @(negedge clock) arm_store = 1'b0;
        repeat (SETUP - 2) @(negedge clock);
        chk("setup ignore", n0, n_start);
        wait_done(100);
        ext_trigger = 1'b0;
        chk("ext start", n0 + 1, n_start);
        trig_source = MTSEQ_SRC_IMM;
        trigger_count = 16'h0002;
        n0 = n_start;
        @(negedge clock) local_mode = 1'b1;
        wait_done(100);
        local_mode = 1'b0;
        chk("local start", n0 + 1, n_start);
        trigger_infinite = 1'b1;
        repeat (3) @(negedge clock);
        chk("inf code", MTSEQ_COUNT_INF_CODE, trig_count_report);
        arm_store = 1'b1;
        @(negedge clock) arm_store = 1'b0;
        repeat (40) @(negedge clock);
        chk("infinite busy", 1, busy);
        device_clear = 1'b1;
        @(negedge clock) device_clear = 1'b0;
        repeat (3) @(negedge clock);
        chk("cleared busy", 0, busy);
        remote_reset = 1'b1;
        @(negedge clock) remote_reset = 1'b0;
        repeat (2) @(negedge clock);
        chk("reset auto_delay", 1, auto_delay);
        close_out();
    end
endmodule

bind mtseq_top mtseq_checker u_chk (.clock, .rst_n, .arm_store, .remote_reset, .device_clear,
    .local_mode, .fetch_req, .reading_memory_feed, .trigger_infinite, .math_on, .math_select,
    .sample_valid, .sample_data, .sample_start, .stats, .trig_count_report, .stats_active,
    .scale_active, .busy, .done, .fetch_error);
`default_nettype wire
